// ===== hlt_timer_consts.vh
// constants for the hardware limit timer mode and output block
// assumes inclusion by the timer design, checker and bench files; one 32-bit word per reg
`ifndef HLT_TIMER_CONSTS_VH
`define HLT_TIMER_CONSTS_VH

// register byte offsets
`define OFF_TIMER_CONTROL   8'h00
`define OFF_LIMIT_CONTROL   8'h04
`define OFF_EXT_RESET_SEL   8'h08
`define OFF_PERIOD_VALUE    8'h0C
`define OFF_COUNT_VALUE     8'h10
`define OFF_TIMER_STATUS    8'h14

// control register fields
`define CTRL_ON_BIT         0
`define CTRL_PS_LSB         1
`define CTRL_PS_MSB         4

// reset values
`define RST_PERIOD          8'hFF
`define RST_COUNT           8'h00
`define RST_MODE            5'h00
`define RST_SEL             3'h0
`define RST_POST            4'h0

// mode upper bits
`define MODE_FREE           2'h0
`define MODE_ONESHOT        2'h1
`define MODE_MONO           2'h2

`endif

// ===== hw_limit_timer_mode_control.v
// mode control, counter, postscaler and register slave of the limit timer
// assumes timer_clock_tick_i is a one-cycle prescaler-full strobe on mclk_i
// and that external reset sources may come from any clock domain
`timescale 1ns/1ps
`include "hlt_timer_consts.vh"

module hw_limit_timer_mode_control (
    // clock and reset
    input  wire        mclk_i,
    input  wire        rstn_i,
    // ahb-lite slave
    input  wire        hsel_i,
    input  wire [7:0]  haddr_i,
    input  wire [1:0]  htrans_i,
    input  wire        hwrite_i,
    input  wire [2:0]  hsize_i,
    input  wire [31:0] hwdata_i,
    input  wire        hready_i,
    output wire        hreadyout_o,
    output wire        hresp_o,
    output reg  [31:0] hrdata_o,
    // timer tick and external reset sources
    input  wire        timer_clock_tick_i,
    input  wire [7:0]  ext_reset_src_i,
    input  wire        debug_freeze_i,
    // outputs to other blocks
    output reg         postscaled_pulse_o,
    output reg         prescaler_clear_o,
    output wire [7:0]  count_value_o,
    output wire [7:0]  period_active_o,
    output wire        period_match_o
);

    // software visible state
    reg        timer_on;
    reg [3:0]  postscale_match_select;
    reg [4:0]  limit_mode;
    reg [2:0]  ext_reset_select;
    reg [7:0]  period_value;
    reg [7:0]  period_active;
    reg [7:0]  count_value;
    reg [3:0]  post_cnt;
    reg        started;

    // bus data phase state
    reg        wr_pend;
    reg [7:0]  wr_addr;

    // external reset synchroniser and edge history
    reg [7:0]  ers_meta;
    reg [7:0]  ers_sync;
    reg        ers_eff;
    reg        ers_prev;

    // per-tick decode results
    reg        run;
    reg        hold_rst;
    reg        edge_rst;
    reg        next_started;
    reg        end_clears_on;
    reg        end_stops;

    wire       addr_phase;
    wire       wr_ctrl;
    wire       wr_limit;
    wire       wr_count;
    wire       rise;
    wire       fall;
    wire       match;
    wire       hw_event;
    wire       sw_clear;
    wire       ers_sel;
    wire [1:0] mode_hi;
    wire [2:0] mode_lo;

    // read mux shared by the address phase
    function [31:0] read_word;
        input [7:0] a;
        begin
            case (a)
                `OFF_TIMER_CONTROL: read_word = {27'h0,
                    postscale_match_select, timer_on};
                `OFF_LIMIT_CONTROL: read_word = {27'h0, limit_mode};
                `OFF_EXT_RESET_SEL: read_word = {29'h0, ext_reset_select};
                `OFF_PERIOD_VALUE:  read_word = {24'h0, period_value};
                `OFF_COUNT_VALUE:   read_word = {24'h0, count_value};
                `OFF_TIMER_STATUS:  read_word = {19'h0, period_active,
                    post_cnt, run};
                default:            read_word = 32'h0;
            endcase
        end
    endfunction

    // zero-wait slave, always okay
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
    assign addr_phase  = hsel_i & htrans_i[1] & hready_i;

    assign wr_ctrl  = wr_pend & (wr_addr == `OFF_TIMER_CONTROL);
    assign wr_limit = wr_pend & (wr_addr == `OFF_LIMIT_CONTROL);
    assign wr_count = wr_pend & (wr_addr == `OFF_COUNT_VALUE);
    assign sw_clear = wr_ctrl | wr_count;

    // capture address phase, return read data in the data phase
    always @(posedge mclk_i) begin
        if (!rstn_i) begin
            wr_pend  <= 1'b0;
            wr_addr  <= 8'h00;
            hrdata_o <= 32'h0;
        end else begin
            wr_pend  <= addr_phase & hwrite_i;
            wr_addr  <= haddr_i;
            if (addr_phase & ~hwrite_i) begin
                hrdata_o <= read_word(haddr_i);
            end
        end
    end

    // two-flop synchroniser on every candidate source
    always @(posedge mclk_i) begin
        if (!rstn_i) begin
            ers_meta <= 8'h00;
            ers_sync <= 8'h00;
        end else begin
            ers_meta <= ext_reset_src_i;
            ers_sync <= ers_meta;
        end
    end

    assign ers_sel = ers_sync[ext_reset_select];

    // freeze holds the effective level, so no edge or level change is seen
    always @(posedge mclk_i) begin
        if (!rstn_i) begin
            ers_eff  <= 1'b0;
            ers_prev <= 1'b0;
        end else begin
            if (!debug_freeze_i) begin
                ers_eff <= ers_sel;
            end
            if (timer_clock_tick_i) begin
                ers_prev <= ers_eff;
            end
        end
    end

    assign rise    = ers_eff & ~ers_prev;
    assign fall    = ~ers_eff & ers_prev;
    assign mode_hi = limit_mode[4:3];
    assign mode_lo = limit_mode[2:0];
    assign match   = (count_value == period_active);

    // mode decode: run, level reset, edge reset and start tracking
    always @* begin
        run           = 1'b0;
        hold_rst      = 1'b0;
        edge_rst      = 1'b0;
        next_started  = started & timer_on;
        end_clears_on = 1'b0;
        end_stops     = 1'b0;
        case (mode_hi)
            `MODE_FREE: begin
                case (mode_lo)
                    3'h1:    run = timer_on & ers_eff;
                    3'h2:    run = timer_on & ~ers_eff;
                    3'h3: begin
                        run      = timer_on;
                        edge_rst = timer_on & (rise | fall);
                    end
                    3'h4: begin
                        run      = timer_on;
                        edge_rst = timer_on & rise;
                    end
                    3'h5: begin
                        run      = timer_on;
                        edge_rst = timer_on & fall;
                    end
                    3'h6: begin
                        hold_rst = timer_on & ~ers_eff;
                        run      = timer_on & ers_eff;
                    end
                    3'h7: begin
                        hold_rst = timer_on & ers_eff;
                        run      = timer_on & ~ers_eff;
                    end
                    default: run = timer_on;
                endcase
            end
            `MODE_ONESHOT: begin
                end_clears_on = 1'b1;
                case (mode_lo)
                    3'h0:    next_started = timer_on;
                    3'h1:    next_started = timer_on & (started | rise);
                    3'h2:    next_started = timer_on & (started | fall);
                    3'h3:    next_started = timer_on &
                                 (started | rise | fall);
                    3'h4: begin
                        edge_rst     = started & rise;
                        next_started = timer_on & (started | rise);
                    end
                    3'h5: begin
                        edge_rst     = started & fall;
                        next_started = timer_on & (started | fall);
                    end
                    3'h6: begin
                        hold_rst     = started & ~ers_eff;
                        next_started = timer_on & (started | rise);
                    end
                    default: begin
                        hold_rst     = started & ers_eff;
                        next_started = timer_on & (started | fall);
                    end
                endcase
                run = started & timer_on & ~hold_rst;
            end
            `MODE_MONO: begin
                case (mode_lo)
                    3'h1, 3'h2, 3'h3: begin
                        end_stops = 1'b1;
                        if (mode_lo[0]) begin
                            next_started = timer_on & (started | rise);
                        end
                        if (mode_lo[1]) begin
                            next_started = timer_on &
                                (started | fall | (mode_lo[0] & rise));
                        end
                        run = started & timer_on;
                    end
                    3'h6: begin
                        end_clears_on = 1'b1;
                        hold_rst = timer_on & ~ers_eff;
                        run      = timer_on & ers_eff;
                    end
                    3'h7: begin
                        end_clears_on = 1'b1;
                        hold_rst = timer_on & ers_eff;
                        run      = timer_on & ~ers_eff;
                    end
                    default: next_started = 1'b0;
                endcase
            end
            default: next_started = 1'b0;
        endcase
    end

    // an external event that resets the timer on this tick
    assign hw_event = timer_clock_tick_i & (hold_rst | edge_rst);

    // count, postscaler, period buffer and enable
    always @(posedge mclk_i) begin
        if (!rstn_i) begin
            timer_on               <= 1'b0;
            postscale_match_select <= `RST_POST;
            limit_mode             <= `RST_MODE;
            ext_reset_select       <= `RST_SEL;
            period_value           <= `RST_PERIOD;
            period_active          <= `RST_PERIOD;
            count_value            <= `RST_COUNT;
            post_cnt               <= `RST_POST;
            started                <= 1'b0;
            postscaled_pulse_o     <= 1'b0;
            prescaler_clear_o      <= 1'b0;
        end else begin
            prescaler_clear_o <= sw_clear | hw_event;
            if (timer_clock_tick_i) begin
                started            <= next_started;
                postscaled_pulse_o <= 1'b0;
                if (hold_rst | edge_rst) begin
                    // edge reset keeps the run going from 00h
                    count_value   <= 8'h00;
                    post_cnt      <= 4'h0;
                    period_active <= period_value;
                end else if (run & match) begin
                    count_value   <= 8'h00;
                    period_active <= period_value;
                    if (post_cnt == postscale_match_select) begin
                        postscaled_pulse_o <= 1'b1;
                        post_cnt <= 4'h0;
                    end else begin
                        post_cnt <= post_cnt + 4'h1;
                    end
                    if (end_clears_on) begin
                        timer_on <= 1'b0;
                        started  <= 1'b0;
                    end
                    if (end_stops) begin
                        started <= 1'b0;
                    end
                end else if (run) begin
                    count_value <= count_value + 8'h01;
                end
            end
            // software writes take priority over the tick
            if (wr_ctrl) begin
                timer_on               <= hwdata_i[`CTRL_ON_BIT];
                postscale_match_select <=
                    hwdata_i[`CTRL_PS_MSB:`CTRL_PS_LSB];
            end
            if (wr_limit) begin
                limit_mode <= hwdata_i[4:0];
            end
            if (wr_pend & (wr_addr == `OFF_EXT_RESET_SEL)) begin
                ext_reset_select <= hwdata_i[2:0];
            end
            if (wr_pend & (wr_addr == `OFF_PERIOD_VALUE)) begin
                period_value <= hwdata_i[7:0];
            end
            if (wr_count) begin
                count_value <= hwdata_i[7:0];
            end
            if (sw_clear | wr_limit) begin
                period_active <= wr_pend &
                    (wr_addr == `OFF_PERIOD_VALUE) ?
                    hwdata_i[7:0] : period_value;
            end
            if (sw_clear) begin
                post_cnt <= 4'h0;
            end
        end
    end

    // count and match go to the pwm compare unit
    assign count_value_o   = count_value;
    assign period_active_o = period_active;
    assign period_match_o  = match & run;

endmodule

// ===== hw_limit_timer_mode_control_assertions.sv
// checker for the limit timer mode block, bound to its top module
// assumes writes land at the data-phase edge and a one-cycle tick strobe
`timescale 1ns/1ps
`include "hlt_timer_consts.vh"

module lt_mode_checker (
    // clock and reset
    input logic        mclk_i,
    input logic        rstn_i,
    // bus side
    input logic        hsel_i,
    input logic [7:0]  haddr_i,
    input logic [1:0]  htrans_i,
    input logic        hwrite_i,
    input logic [31:0] hwdata_i,
    input logic        hready_i,
    // timer side
    input logic        timer_clock_tick_i,
    input logic        postscaled_pulse_o,
    input logic        prescaler_clear_o,
    input logic [7:0]  count_value_o,
    input logic        period_match_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    logic       pend;
    logic [4:0] mode;
    wire        take = hsel_i && htrans_i[1] && hready_i;
    wire        rsv  = mode[4:3] == 2'h3;
    // shadow of the mode field
    always @(posedge mclk_i) begin
        if (!rstn_i) begin
            pend <= 1'b0;
            mode <= 5'h00;
        end else begin
            pend <= take && hwrite_i && haddr_i == `OFF_LIMIT_CONTROL;
            if (pend)
                mode <= hwdata_i[4:0];
        end
    end
    sequence ctrl_write;
        take && hwrite_i && haddr_i == `OFF_TIMER_CONTROL;
    endsequence
    chk_match_clear: assert property (
        timer_clock_tick_i && period_match_o |=> count_value_o == 8'h00)
        else $error("count not cleared after match");
    chk_count_step: assert property (
        count_value_o != 8'h00 && $changed(count_value_o) |->
        $past(timer_clock_tick_i) &&
        count_value_o == $past(count_value_o) + 8'h01)
        else $error("count moved off a tick or by more than one");
    chk_pulse_start: assert property (
        $rose(postscaled_pulse_o) |->
        $past(timer_clock_tick_i) && $past(period_match_o))
        else $error("pulse rose without a period match");
    chk_pulse_end: assert property (
        postscaled_pulse_o && timer_clock_tick_i && !period_match_o
        |=> !postscaled_pulse_o) else $error("pulse longer than one tick");
    chk_pulse_fall: assert property (
        $fell(postscaled_pulse_o) |-> $past(timer_clock_tick_i))
        else $error("pulse ended off a tick");
    chk_presc_clear: assert property (
        ctrl_write |-> ##[1:3] prescaler_clear_o)
        else $error("no prescaler clear after control write");
    chk_rsv_idle: assert property (
        rsv && $past(rsv) |-> $stable(count_value_o) && !period_match_o)
        else $error("counter moved in reserved mode");
    chk_stop_zero: assert property (
        mode[4:3] != 2'h0 && timer_clock_tick_i && period_match_o
        |=> (count_value_o == 8'h00) [*8])
        else $error("one-shot did not stop");
endmodule

// ===== ext_reset_source.sv
// model of the logic that drives the external reset lines
// assumes tick_i is the timer tick strobe on mclk_i
`timescale 1ns/1ps

module ext_reset_source (
    // clock, reset and tick
    input  logic       mclk_i,
    input  logic       rstn_i,
    input  logic       tick_i,
    // requested level and line
    input  logic       level_i,
    input  logic [2:0] line_i,
    output logic [7:0] src_o
);
    logic       cur;
    logic [3:0] gap;
    // follow the request only after six quiet ticks
    always @(posedge mclk_i) begin
        if (!rstn_i) begin
            cur <= 1'b0;
            gap <= 4'h0;
        end else if (tick_i) begin
            if (level_i != cur && gap >= 4'h6) begin
                cur <= level_i;
                gap <= 4'h0;
            end else if (gap != 4'hF) begin
                gap <= gap + 4'h1;
            end
        end
    end
    // other lines carry the opposite level
    always @* begin
        src_o = {8{~cur}};
        src_o[line_i] = cur;
    end
endmodule

// ===== hw_limit_timer_mode_control_test.sv
// self-checking bench for the limit timer mode block
// assumes the block answers every bus transfer with hreadyout high
`timescale 1ns/1ps
`include "hlt_timer_consts.vh"

module hw_limit_timer_mode_control_test;
    localparam int TP = 4;
    logic        mclk_i   = 1'b0;
    logic        rstn_i   = 1'b0;
    logic        hsel_i   = 1'b0;
    logic [7:0]  haddr_i  = 8'h00;
    logic [1:0]  htrans_i = 2'h0;
    logic        hwrite_i = 1'b0;
    logic [31:0] hwdata_i = 32'h0;
    logic        tick     = 1'b0;
    logic        freeze   = 1'b0;
    logic        want     = 1'b0;
    logic [1:0]  tdiv     = 2'h0;
    logic        pulse_d  = 1'b0;
    logic [31:0] lvl [2]  = '{32'h01, 32'h06};
    logic [7:0]  src, count, period_act;
    logic [31:0] hrdata_o;
    logic        hreadyout_o, hresp_o, ps_clr, pulse, match;
    int          miscompares = 0;
    int          check_count = 0;
    int          npulse = 0;
    int          n, c0;

    always #5 mclk_i = ~mclk_i;
    // tick every fourth clock, count pulses
    always @(posedge mclk_i) begin
        tdiv <= tdiv + 2'h1;
        tick <= tdiv == 2'h3;
        pulse_d <= pulse;
        if (pulse && !pulse_d)
            npulse <= npulse + 1;
    end

    hw_limit_timer_mode_control i_dut (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
        .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o),
        .timer_clock_tick_i(tick), .ext_reset_src_i(src),
        .debug_freeze_i(freeze), .postscaled_pulse_o(pulse),
        .prescaler_clear_o(ps_clr), .count_value_o(count),
        .period_active_o(period_act), .period_match_o(match));
    ext_reset_source i_src (.mclk_i(mclk_i), .rstn_i(rstn_i), .tick_i(tick),
        .level_i(want), .line_i(3'h3), .src_o(src));

    task chk(input string nm, input [31:0] e, input [31:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task xfer(input w, input [7:0] a, input [31:0] d, output [31:0] r);
        // launch the address phase right on a clock edge
        @(posedge mclk_i);
        hsel_i <= 1'b1; htrans_i <= 2'h2; haddr_i <= a; hwrite_i <= w;
        do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
        hsel_i <= 1'b0; htrans_i <= 2'h0; hwdata_i <= d;
        do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
        r = hrdata_o;
    endtask
    task wr(input [7:0] a, input [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask
    task rd(input [7:0] a, input [31:0] e, input string nm);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0, r);
        chk(nm, e, r);
        chk("hresp", 32'h0, hresp_o);
    endtask
    task cyc(input int k);
        repeat (k) @(posedge mclk_i);
        #1;
    endtask
    // clocks from pulse end to the next pulse start
    task pgap(output int k);
        k = 0;
        while (pulse !== 1'b1) cyc(1);
        while (pulse !== 1'b0) cyc(1);
        while (pulse !== 1'b1) begin
            cyc(1);
            k++;
        end
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // watchdog
    initial begin
        repeat (5000) @(posedge mclk_i);
        miscompares++;
        end_sim;
    end

    initial begin
        repeat (6) @(posedge mclk_i);
        rstn_i <= 1'b1;
        @(posedge mclk_i);
        rd(`OFF_PERIOD_VALUE, 32'hFF, "period_rst");
        rd(`OFF_COUNT_VALUE, 32'h0, "count_rst");
        rd(8'h1C, 32'h0, "unmapped");
        wr(`OFF_EXT_RESET_SEL, 32'h3);
        wr(`OFF_PERIOD_VALUE, 32'h2);
        cyc(2);
        chk("active_hold", 32'hFF, period_act);
        wr(`OFF_TIMER_CONTROL, 32'h3);
        cyc(2);
        chk("active_load", 32'h2, period_act);
        pgap(n);
        chk("pulse_gap", 2 * 3 * TP - TP, n);
        wr(`OFF_TIMER_CONTROL, 32'h0);
        wr(`OFF_LIMIT_CONTROL, 32'h08);
        c0 = npulse;
        wr(`OFF_TIMER_CONTROL, 32'h1);
        cyc(40);
        rd(`OFF_TIMER_CONTROL, 32'h0, "oneshot_on");
        chk("oneshot_pulse", c0 + 1, npulse);
        wr(`OFF_LIMIT_CONTROL, 32'h11);
        wr(`OFF_TIMER_CONTROL, 32'h1);
        c0 = npulse;
        cyc(40);
        chk("mono_wait", c0, npulse);
        want <= 1'b1;
        cyc(40);
        chk("mono_pulse", c0 + 1, npulse);
        rd(`OFF_TIMER_CONTROL, 32'h1, "mono_on");
        wr(`OFF_PERIOD_VALUE, 32'hFF);
        foreach (lvl[i]) begin
            want <= 1'b0;
            wr(`OFF_LIMIT_CONTROL, lvl[i]);
            wr(`OFF_COUNT_VALUE, 32'h0);
            wr(`OFF_TIMER_CONTROL, 32'h1);
            cyc(40);
            chk("lvl_stop", 32'h0, count);
            want <= 1'b1;
            cyc(40);
            chk("lvl_run", 32'h1, count > 8'h00);
        end
        wr(`OFF_LIMIT_CONTROL, 32'h04);
        want <= 1'b0;
        cyc(40);
        freeze <= @(posedge mclk_i) 1'b1;
        c0 = count;
        want <= 1'b1;
        cyc(40);
        chk("frozen", 32'h1, count > c0[7:0]);
        freeze <= @(posedge mclk_i) 1'b0;
        want <= 1'b0;
        cyc(40);
        want <= 1'b1;
        cyc(12);
        chk("edge_rst", 32'h1, count > 8'h0 && count < 8'h8);
        wr(`OFF_TIMER_CONTROL, 32'h0);
        wr(`OFF_COUNT_VALUE, 32'h0);
        wr(`OFF_LIMIT_CONTROL, 32'h18);
        wr(`OFF_TIMER_CONTROL, 32'h1);
        c0 = npulse;
        cyc(60);
        chk("rsv_count", 32'h0, count);
        chk("rsv_pulse", c0, npulse);
        end_sim;
    end
endmodule

bind hw_limit_timer_mode_control lt_mode_checker i_chk (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i),
    .hready_i(hready_i), .timer_clock_tick_i(timer_clock_tick_i),
    .postscaled_pulse_o(postscaled_pulse_o),
    .prescaler_clear_o(prescaler_clear_o),
    .count_value_o(count_value_o), .period_match_o(period_match_o));
